// ### rtl/ifram_regs.vh
// Constants for the two-wire serial memory slave
`ifndef IFRAM_REGS_VH
`define IFRAM_REGS_VH
// ----------------------------------------
// Address and array layout
// ----------------------------------------
`define IFRAM_ADDR_W 13
`define IFRAM_DEPTH 8192
`define IFRAM_ADDR_LAST 13'h1FFF
`define IFRAM_ADDR_ZERO 13'h0000
// Slave address byte fields
`define IFRAM_TYPE_HI 7
`define IFRAM_TYPE_LO 4
`define IFRAM_SEL_HI 3
`define IFRAM_SEL_LO 1
`define IFRAM_RW_BIT 0
// Device type code, arbitrary value
`define IFRAM_TYPE_CODE 4'h5
// ----------------------------------------
// Link timing
// ----------------------------------------
`define IFRAM_SYS_CLK_HZ 50000000
`define IFRAM_SCL_MAX_HZ 1000000
// Sys cycles per fastest link period, rounded down
`define IFRAM_SCL_MIN_CYC (`IFRAM_SYS_CLK_HZ / `IFRAM_SCL_MAX_HZ)
`endif

// ### rtl/ifram_sync.v
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module ifram_sync (
  input wire clock,
  input wire sys_rst,
  input wire din,
  output reg dout
);
  reg meta_reg;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule

// ### rtl/ifram_slave.v
// Two-wire serial slave with 8K x 8 byte array
`timescale 1ns/1ps
`include "ifram_regs.vh"
// Overview of operation
// - Each received data byte is written to the array on its eighth bit, unless write protect is high.
// - No busy state; next transaction accepted right after a write.
// - Respond only when address select bits equal the select pins.
// - Floating select pins read as zero (pull-down outside the core).
// - Data line only pulled low or released, never driven high.
// - Output changes after clock falls; input sampled at clock rise.
// - Write protect high blocks all array writes; low allows all.
// - Floating write protect reads as zero, memory writable.
// - Array holds 8192 bytes of eight bits each.
// - Link clock up to 1 MHz, including 100 and 400 kHz.
// - Address byte: bits 3..1 select, bit 0 one means read.
// - Write carries two address bytes; only low 13 bits used.
// - Address increments after each data byte, wraps 1FFF to 0000.
// - Read sends bytes MSB first until master gives no acknowledge.
module ifram_slave (
  input wire clock,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire [2:0] device_select_pins,
  input wire write_protect
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_DEV = 3'd1;
  localparam ST_AHI = 3'd2;
  localparam ST_ALO = 3'd3;
  localparam ST_WDAT = 3'd4;
  localparam ST_RDAT = 3'd5;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire scl_s;
  wire sda_s;
  wire wp_s;
  wire [2:0] sel_s;
  ifram_sync u_scl (.clock(clock), .sys_rst(sys_rst), .din(scl_in), .dout(scl_s));
  ifram_sync u_sda (.clock(clock), .sys_rst(sys_rst), .din(sda_in), .dout(sda_s));
  ifram_sync u_wp (.clock(clock), .sys_rst(sys_rst), .din(write_protect), .dout(wp_s));
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sel
      ifram_sync u_sel (.clock(clock), .sys_rst(sys_rst), .din(device_select_pins[gi]), .dout(sel_s[gi]));
    end
  endgenerate

  // ----------------------------------------
  // Edge and condition detection
  // ----------------------------------------
  reg scl_d_reg;
  reg sda_d_reg;
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  // 20 ns sampling resolves any link clock up to the maximum rate
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------
  // Memory array
  // ----------------------------------------
  reg [7:0] mem [0:`IFRAM_DEPTH-1];
  reg [`IFRAM_ADDR_W-1:0] addr_reg;
  reg [7:0] mem_rd;
  reg mem_we;
  reg [7:0] mem_wd;
  always @(posedge clock) begin
    if (mem_we) begin
      mem[addr_reg] <= mem_wd;
    end
    mem_rd <= mem[addr_reg];
  end

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  // Bit counter: rises 1..8 are data, rise 9 is the acknowledge slot
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [3:0] bit_reg;
  reg [3:0] bit_next;
  reg [7:0] shift_reg;
  reg [7:0] shift_next;
  reg [`IFRAM_ADDR_W-1:0] addr_next;
  reg oe_next;
  reg we_next;
  reg [7:0] wd_next;
  wire [7:0] byte_in = {shift_reg[6:0], sda_s};
  wire [`IFRAM_ADDR_W-1:0] addr_inc = (addr_reg == `IFRAM_ADDR_LAST) ? `IFRAM_ADDR_ZERO :
    addr_reg + 13'h0001;
  wire type_ok = (shift_reg[`IFRAM_TYPE_HI:`IFRAM_TYPE_LO] == `IFRAM_TYPE_CODE);
  wire sel_ok = (shift_reg[`IFRAM_SEL_HI:`IFRAM_SEL_LO] == sel_s);
  wire dev_match = type_ok & sel_ok;

  always @* begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    oe_next = sda_oe;
    we_next = 1'b0;
    wd_next = mem_wd;
    if (start_cond) begin
      // A start aborts whatever was in progress
      state_next = ST_DEV;
      bit_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop_cond) begin
      state_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (state_reg != ST_IDLE && scl_rise) begin
      // Sample on the rising edge
      bit_next = bit_reg + 4'h1;
      if (bit_reg == 4'h8) begin
        if (state_reg == ST_RDAT && sda_s) begin
          // Master gave no acknowledge
          state_next = ST_IDLE;
        end
      end else if (state_reg != ST_RDAT) begin
        shift_next = byte_in;
        if (bit_reg == 4'h7 && state_reg == ST_WDAT && !wp_s) begin
          wd_next = byte_in;
          we_next = 1'b1;
        end
      end
    end else if (state_reg != ST_IDLE && scl_fall) begin
      // Outputs change only after the falling edge
      if (bit_reg == 4'h9) begin
        bit_next = 4'h0;
        if (state_reg == ST_RDAT) begin
          // Array read is registered, so the byte is ready long before this edge
          shift_next = mem_rd;
          oe_next = ~mem_rd[7];
          addr_next = addr_inc;
        end else begin
          oe_next = 1'b0;
        end
      end else if (bit_reg == 4'h8) begin
        case (state_reg)
          ST_DEV: begin
            if (dev_match) begin
              oe_next = 1'b1;
              if (shift_reg[`IFRAM_RW_BIT]) begin
                state_next = ST_RDAT;
              end else begin
                state_next = ST_AHI;
              end
            end else begin
              state_next = ST_IDLE;
            end
          end
          ST_AHI: begin
            addr_next[12:8] = shift_reg[4:0];
            oe_next = 1'b1;
            state_next = ST_ALO;
          end
          ST_ALO: begin
            addr_next[7:0] = shift_reg;
            oe_next = 1'b1;
            state_next = ST_WDAT;
          end
          ST_WDAT: begin
            addr_next = addr_inc;
            oe_next = 1'b1;
          end
          ST_RDAT: begin
            // Let go so the master can acknowledge
            oe_next = 1'b0;
          end
          default: begin
            state_next = ST_IDLE;
          end
        endcase
      end else if (state_reg == ST_RDAT && bit_reg != 4'h0) begin
        oe_next = ~shift_reg[3'h7 - bit_reg[2:0]];
      end
    end
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= `IFRAM_ADDR_ZERO;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      mem_we <= 1'b0;
      mem_wd <= 8'h00;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      sda_out <= 1'b0;
      sda_oe <= oe_next;
      mem_we <= we_next;
      mem_wd <= wd_next;
    end
  end
endmodule

// ### bench/ifram_slave_props.sv
// Port checker for the serial memory slave
`timescale 1ns/1ps
module ifram_slave_props (
  input wire clock,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [2:0] device_select_pins,
  input wire write_protect
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Framing events
  // ----------------------------------------
  sequence stop_seen;
    $rose(sda_in) && scl_in && $past(scl_in);
  endsequence
  sequence start_seen;
    $fell(sda_in) && scl_in && $past(scl_in);
  endsequence
  AST_PULL_ONLY: assert property (sda_out == 1'b0) else $error("data driven high");
  AST_WIRE_LOW: assert property (sda_oe |-> !sda_in) else $error("pull not on wire");
  AST_RISE_LOW: assert property ($rose(sda_oe) |-> !$past(scl_in, 2)) else $error("pull in high phase");
  AST_FALL_LOW: assert property ($fell(sda_oe) |-> !$past(scl_in, 2)) else $error("release in high phase");
  AST_HOLD_HIGH: assert property ($rose(scl_in) |=> $stable(sda_oe) [*3]) else $error("moved while high");
  AST_MIN_BIT: assert property ($rose(sda_oe) |-> sda_oe [*4]) else $error("pulled bit too short");
  AST_STOP_FREE: assert property (stop_seen |-> !sda_oe) else $error("pulling at stop");
  AST_START_FREE: assert property (start_seen |=> !sda_oe [*2]) else $error("pulling at start");
endmodule
bind ifram_slave ifram_slave_props ifram_slave_props_inst (.clock(clock), .sys_rst(sys_rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .device_select_pins(device_select_pins),
  .write_protect(write_protect));

// ### bench/ifram_master.sv
// Bus master model for the two-wire link
`timescale 1ns/1ps
module ifram_master (
  input wire clock,
  input wire sda,
  output logic scl,
  output logic sda_drv
);
  int half = 4; // 4 is the fast rate, 25 gives 1 us per bit
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hp;
    repeat (half) @(negedge clock);
  endtask
  // Also a repeated start; clock stands high when idle
  task automatic start;
    @(negedge clock);
    sda_drv = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_drv = 1'b0;
    hp;
    scl = 1'b0;
  endtask
  task automatic stop;
    @(negedge clock);
    sda_drv = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_drv = 1'b1;
  endtask
  // Data moves one cycle after the fall, so no false start or stop
  task automatic xbit(input logic b, output logic r);
    @(negedge clock);
    sda_drv = b;
    hp;
    scl = 1'b1;
    hp;
    r = sda;
    scl = 1'b0;
  endtask
  // Top bit first, ninth slot is the acknowledge
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(a, nak);
  endtask
endmodule

// ### bench/tb.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
`include "ifram_regs.vh"
module tb;
  logic clock = 1'b0, sys_rst = 1'b1, write_protect = 1'b0, n;
  logic [2:0] device_select_pins = 3'h5;
  logic [7:0] q;
  int num_errors = 0, checks = 0;
  wire sda_oe, sda_out, scl, sda_drv;
  wire sda_in = sda_drv & ~sda_oe;
  initial forever #10 clock = ~clock;
  ifram_slave ifram_slave_inst (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .device_select_pins(device_select_pins), .write_protect(write_protect));
  ifram_master ifram_master_inst (.clock(clock), .sda(sda_in), .scl(scl), .sda_drv(sda_drv));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Byte out, acknowledge level compared
  task automatic tx(input logic [7:0] d, input logic [7:0] ack);
    ifram_master_inst.xbyte(d, 1'b1, q, n);
    chk({7'h00, n}, ack);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d [$]);
    ifram_master_inst.start;
    tx({`IFRAM_TYPE_CODE, device_select_pins, 1'b0}, 8'h00);
    tx(a[15:8], 8'h00);
    tx(a[7:0], 8'h00);
    foreach (d[i]) tx(d[i], 8'h00);
  endtask
  // Random read: address phase, repeated start, no ack on last byte
  task automatic rd(input logic [15:0] a, input logic [7:0] e [$]);
    wr(a, '{});
    ifram_master_inst.start;
    tx({`IFRAM_TYPE_CODE, device_select_pins, 1'b1}, 8'h00);
    foreach (e[i]) begin
      ifram_master_inst.xbyte(8'hFF, i == e.size() - 1, q, n);
      chk(q, e[i]);
    end
    ifram_master_inst.stop;
  endtask
  task automatic t_burst_wrap;
    wr(16'hFFFE, '{8'hA5, 8'h3C, 8'h96});
    ifram_master_inst.stop;
    rd(16'h1FFE, '{8'hA5, 8'h3C, 8'h96});
  endtask
  task automatic t_protect;
    write_protect = 1'b1;
    wr(16'h0000, '{8'h5A});
    ifram_master_inst.stop;
    write_protect = 1'b0;
    rd(16'h0000, '{8'h96});
  endtask
  task automatic t_select;
    ifram_master_inst.start;
    tx({`IFRAM_TYPE_CODE, 3'h2, 1'b0}, 8'h01);
    tx(8'h00, 8'h01);
    ifram_master_inst.stop;
    device_select_pins = 3'h0;
    rd(16'h1FFF, '{8'h3C});
    device_select_pins = 3'h5;
  endtask
  task automatic t_slow;
    ifram_master_inst.half = 25;
    wr(16'h0100, '{8'hC3});
    ifram_master_inst.stop;
    rd(16'h0100, '{8'hC3});
    ifram_master_inst.half = 4;
  endtask
  task automatic wrap_up;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    t_burst_wrap;
    t_protect;
    t_select;
    t_slow;
    wrap_up;
  end
  // Run needs well under 0.5 ms
  initial begin
    #2000000;
    num_errors++;
    wrap_up;
  end
endmodule
